// [verilog/cia_pkg.sv]
// Constants and types shared by the interrupt arbiter files
`default_nettype none
package cia_pkg;
    localparam int unsigned NCHAN = 8;
    localparam int unsigned PADDR_W = 10;
    // Register indexes; byte address is four times the index
    localparam logic [7:0] IDX_CTRL = 8'he6;
    localparam logic [7:0] IDX_EDGE = 8'hf2;
    localparam logic [7:0] IDX_PEND = 8'hf3;
    localparam logic [7:0] IDX_MASK = 8'hf4;
    localparam logic [7:0] IDX_PRIO = 8'hf5;
    localparam logic [7:0] IDX_VECT = 8'hf6;
    localparam logic [7:0] IDX_LOCK = 8'hf7;
    localparam logic [7:0] IDX_STAT = 8'hf8;
    // Reset values
    localparam logic [7:0] CTRL_RST = 8'h87;
    localparam logic [7:0] EDGE_RST = 8'h00;
    localparam logic [7:0] PEND_RST = 8'h00;
    localparam logic [7:0] MASK_RST = 8'h00;
    localparam logic [7:0] PRIO_RST = 8'hff;
    localparam logic [7:0] VECT_RST = 8'h00;
    // Control, vector and lock register fields, lowest priority code
    localparam int unsigned B_MFT = 7;
    localparam int unsigned B_TOP_LEVEL_PENDING = 6;
    localparam int unsigned B_TLEN = 5;
    localparam int unsigned B_IEN = 4;
    localparam int unsigned B_MODE = 3;
    localparam int unsigned CPL_LSB = 0;
    localparam int unsigned VEC_LSB = 4;
    localparam int unsigned B_TLEDGE = 3;
    localparam int unsigned B_LOCK = 7;
    localparam logic [2:0] PRIO_LOWEST = 3'h7;
    // Top-level vector code, value arbitrary
    localparam logic [6:0] TL_VECTOR = 7'h06;
    // Timing in processor clock cycles
    localparam logic [2:0] ARB_LAST = 3'h4;
    localparam logic [4:0] IMC_BASE = 5'h12;
    localparam logic [4:0] IMC_STACK_RF = 5'h02;
    localparam logic [4:0] IMC_SEG_PUSH = 5'h02;
    localparam logic [4:0] IMC_WAKE = 5'h01;
    typedef enum {CIA_IDLE, CIA_REQ, CIA_ACK, CIA_IMC} cia_state_t;
endpackage
`default_nettype wire

// [verilog/cia_imc_if.sv]
// Link between the arbiter and its machine-cycle timer
`default_nettype none
interface cia_imc_if;
    logic start;
    logic [4:0] cycles;
    logic busy;
    logic done;
    modport ctrl (output start, output cycles, input busy, input done);
    modport timer (input start, input cycles, output busy, output done);
endinterface
`default_nettype wire

// [verilog/cia_imc_timer.sv]
// Counts out the interrupt machine cycle
`default_nettype none
module cia_imc_timer (
    input wire logic i_core_clk,
    input wire logic i_reset_n,
    cia_imc_if.timer imc
);
    logic [4:0] cnt_r;
    logic busy_r;

    always_ff @(posedge i_core_clk) begin
        if (!i_reset_n) begin
            cnt_r <= 5'h00;
            busy_r <= 1'b0;
        end else if (imc.start) begin
            cnt_r <= imc.cycles;
            busy_r <= 1'b1;
        end else if (busy_r) begin
            cnt_r <= cnt_r - 5'h01;
            if (cnt_r == 5'h01) begin
                busy_r <= 1'b0;
            end
        end
    end

    assign imc.busy = busy_r;
    assign imc.done = busy_r && (cnt_r == 5'h01);
endmodule // cia_imc_timer
`default_nettype wire

// [verilog/cia_arbiter.sv]
// Central interrupt arbiter with APB registers
`default_nettype none
module cia_arbiter (
    input wire logic i_core_clk,
    input wire logic i_reset_n,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [cia_pkg::PADDR_W-1:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    input wire logic [cia_pkg::NCHAN-1:0] i_ext_pin,
    input wire logic [cia_pkg::NCHAN-1:0] i_periph_event,
    input wire logic i_top_pin,
    input wire logic i_write_done,
    input wire logic i_instr_end,
    input wire logic i_wfi,
    input wire logic i_stack_in_rf,
    input wire logic i_segment_push_enable,
    input wire logic i_ei,
    input wire logic i_di,
    input wire logic i_iret,
    input wire logic i_iret_top,
    output logic o_int_req,
    output logic o_int_abort,
    output logic o_int_ack,
    output logic o_imc_busy,
    output logic [6:0] o_vector,
    output logic o_top_level,
    output logic o_mft_enable
);
    localparam int unsigned N = cia_pkg::NCHAN;

    logic [7:0] ctrl_r;
    logic [7:0] edge_r;
    logic [7:0] pend_r;
    logic [7:0] mask_r;
    logic [7:0] prio_r;
    logic [7:0] vect_r;
    logic lock_r;
    logic [N-1:0] pin_s1_r;
    logic [N-1:0] pin_s2_r;
    logic [N-1:0] pin_prev_r;
    logic [N-1:0] pin_event;
    logic [2:0] tl_sync_r;
    logic tl_event;
    logic [2:0] phase_r;
    cia_pkg::cia_state_t state_r;
    logic win_top_r;
    logic [2:0] win_chan_r;
    logic [2:0] win_prio_r;
    logic [6:0] vector_r;
    logic [31:0] prdata_r;
    logic wr;
    logic rd;
    logic ack;
    logic top_req;
    logic any_req;
    logic [2:0] best_chan;
    logic [2:0] best_prio;
    logic [4:0] imc_len;
    logic sample;

    cia_imc_if imc ();

    cia_imc_timer u_timer (
        .i_core_clk(i_core_clk),
        .i_reset_n(i_reset_n),
        .imc(imc)
    );

    // Priority of a channel: two stored bits, parity of the channel below
    function automatic logic [2:0] chan_prio(input logic [7:0] pr,
                                             input int unsigned idx);
        logic [1:0] hi;
        hi = pr[(idx/2)*2 +: 2];
        return {hi, idx[0]};
    endfunction

    function automatic logic hit(input logic [cia_pkg::PADDR_W-1:0] a,
                                 input logic [7:0] idx);
        return a == {idx, 2'b00};
    endfunction

    assign wr = i_psel && i_penable && i_pwrite;
    assign rd = i_psel && !i_pwrite;
    assign ack = (state_r == cia_pkg::CIA_ACK);
    assign sample = (phase_r == cia_pkg::ARB_LAST);

    // Two-flop synchronisers, then edge compare on the third stage
    genvar g;
    generate
        for (g = 0; g < N; g++) begin : g_edge
            always_ff @(posedge i_core_clk) begin
                if (!i_reset_n) begin
                    pin_s1_r[g] <= 1'b0;
                    pin_s2_r[g] <= 1'b0;
                    pin_prev_r[g] <= 1'b0;
                end else begin
                    pin_s1_r[g] <= i_ext_pin[g];
                    pin_s2_r[g] <= pin_s1_r[g];
                    pin_prev_r[g] <= pin_s2_r[g];
                end
            end
            assign pin_event[g] = edge_r[g] ?
                (pin_s2_r[g] && !pin_prev_r[g]) :
                (!pin_s2_r[g] && pin_prev_r[g]);
        end
    endgenerate

    always_ff @(posedge i_core_clk) begin
        if (!i_reset_n) begin
            tl_sync_r <= 3'h0;
        end else begin
            tl_sync_r <= {tl_sync_r[1:0], i_top_pin};
        end
    end
    assign tl_event = vect_r[cia_pkg::B_TLEDGE] ?
        (tl_sync_r[1] && !tl_sync_r[2]) :
        (!tl_sync_r[1] && tl_sync_r[2]);

    // Arbitration round counter, free running
    always_ff @(posedge i_core_clk) begin
        if (!i_reset_n) begin
            phase_r <= 3'h0;
        end else if (sample) begin
            phase_r <= 3'h0;
        end else begin
            phase_r <= phase_r + 3'h1;
        end
    end

    // Winner search among enabled channels
    always_comb begin
        logic [2:0] p;
        logic ok;
        p = 3'h0;
        ok = 1'b0;
        any_req = 1'b0;
        best_chan = 3'h0;
        best_prio = cia_pkg::PRIO_LOWEST;
        for (int unsigned i = 0; i < N; i++) begin
            p = chan_prio(prio_r, i);
            ok = pend_r[i] && mask_r[i] && ctrl_r[cia_pkg::B_IEN];
            ok = ok && (p != cia_pkg::PRIO_LOWEST);
            if (ctrl_r[cia_pkg::B_MODE]) begin
                ok = ok && (p < ctrl_r[cia_pkg::CPL_LSB +: 3]);
            end
            if (ok && (!any_req || p < best_prio)) begin
                any_req = 1'b1;
                best_chan = i[2:0];
                best_prio = p;
            end
        end
    end

    assign top_req = ctrl_r[cia_pkg::B_TOP_LEVEL_PENDING] &&
        ((ctrl_r[cia_pkg::B_TLEN] && ctrl_r[cia_pkg::B_IEN]) ||
         lock_r);

    // Request sequencing towards the core
    always_ff @(posedge i_core_clk) begin
        if (!i_reset_n) begin
            state_r <= cia_pkg::CIA_IDLE;
        end else begin
            case (state_r)
                cia_pkg::CIA_IDLE: begin
                    if (sample && (top_req || any_req)) begin
                        state_r <= cia_pkg::CIA_REQ;
                    end
                end
                cia_pkg::CIA_REQ: begin
                    if (!i_write_done || i_instr_end) begin
                        state_r <= cia_pkg::CIA_ACK;
                    end
                end
                cia_pkg::CIA_ACK: begin
                    state_r <= cia_pkg::CIA_IMC;
                end
                cia_pkg::CIA_IMC: begin
                    if (imc.done) begin
                        state_r <= cia_pkg::CIA_IDLE;
                    end
                end
                default: begin
                    state_r <= cia_pkg::CIA_IDLE;
                end
            endcase
        end
    end

    // Latched winner and its vector
    always_ff @(posedge i_core_clk) begin
        if (!i_reset_n) begin
            win_top_r <= 1'b0;
            win_chan_r <= 3'h0;
            win_prio_r <= 3'h0;
            vector_r <= 7'h00;
        end else if (state_r == cia_pkg::CIA_IDLE && sample) begin
            win_top_r <= top_req;
            win_chan_r <= best_chan;
            win_prio_r <= best_prio;
            if (top_req) begin
                vector_r <= cia_pkg::TL_VECTOR;
            end else begin
                vector_r <= {vect_r[cia_pkg::VEC_LSB +: 4],
                             best_chan};
            end
        end
    end

    // Machine cycle length
    always_comb begin
        imc_len = cia_pkg::IMC_BASE;
        if (i_stack_in_rf) begin
            imc_len = imc_len + cia_pkg::IMC_STACK_RF;
        end
        if (i_segment_push_enable) begin
            imc_len = imc_len + cia_pkg::IMC_SEG_PUSH;
        end
        if (i_wfi) begin
            imc_len = imc_len + cia_pkg::IMC_WAKE;
        end
    end
    assign imc.start = ack;
    assign imc.cycles = imc_len;

    // Channel pending flags; a new event wins over any clear
    always_ff @(posedge i_core_clk) begin
        if (!i_reset_n) begin
            pend_r <= cia_pkg::PEND_RST;
        end else begin
            for (int unsigned i = 0; i < N; i++) begin
                if (pin_event[i] || i_periph_event[i]) begin
                    pend_r[i] <= 1'b1;
                end else if (wr && hit(i_paddr, cia_pkg::IDX_PEND)) begin
                    pend_r[i] <= i_pwdata[i];
                end else if (ack && !win_top_r && win_chan_r == i[2:0]) begin
                    pend_r[i] <= 1'b0;
                end
            end
        end
    end

    // Central control register
    always_ff @(posedge i_core_clk) begin
        if (!i_reset_n) begin
            ctrl_r <= cia_pkg::CTRL_RST;
        end else begin
            if (wr && hit(i_paddr, cia_pkg::IDX_CTRL)) begin
                ctrl_r[cia_pkg::B_MFT] <= i_pwdata[cia_pkg::B_MFT];
                ctrl_r[cia_pkg::B_TLEN] <= i_pwdata[cia_pkg::B_TLEN];
                ctrl_r[cia_pkg::B_MODE] <= i_pwdata[cia_pkg::B_MODE];
                ctrl_r[cia_pkg::CPL_LSB +: 3] <=
                    i_pwdata[cia_pkg::CPL_LSB +: 3];
                if (i_pwdata[cia_pkg::B_IEN] ||
                    state_r == cia_pkg::CIA_IDLE) begin
                    ctrl_r[cia_pkg::B_IEN] <=
                        i_pwdata[cia_pkg::B_IEN];
                end
                if (!tl_event) begin
                    ctrl_r[cia_pkg::B_TOP_LEVEL_PENDING] <= i_pwdata[cia_pkg::B_TOP_LEVEL_PENDING];
                end
            end else begin
                if (i_ei || (i_iret && !i_iret_top)) begin
                    ctrl_r[cia_pkg::B_IEN] <= 1'b1;
                end else if (i_di || (ack && !win_top_r)) begin
                    ctrl_r[cia_pkg::B_IEN] <= 1'b0;
                end
                if (ack && !win_top_r && ctrl_r[cia_pkg::B_MODE]) begin
                    ctrl_r[cia_pkg::CPL_LSB +: 3] <= win_prio_r;
                end
                if (!tl_event && ack && win_top_r) begin
                    ctrl_r[cia_pkg::B_TOP_LEVEL_PENDING] <= 1'b0;
                end
            end
            if (tl_event) begin
                ctrl_r[cia_pkg::B_TOP_LEVEL_PENDING] <= 1'b1;
            end
        end
    end

    // Plain software registers
    always_ff @(posedge i_core_clk) begin
        if (!i_reset_n) begin
            edge_r <= cia_pkg::EDGE_RST;
            mask_r <= cia_pkg::MASK_RST;
            prio_r <= cia_pkg::PRIO_RST;
            vect_r <= cia_pkg::VECT_RST;
        end else if (wr) begin
            if (hit(i_paddr, cia_pkg::IDX_EDGE)) begin
                edge_r <= i_pwdata[7:0];
            end
            if (hit(i_paddr, cia_pkg::IDX_MASK)) begin
                mask_r <= i_pwdata[7:0];
            end
            if (hit(i_paddr, cia_pkg::IDX_PRIO)) begin
                prio_r <= i_pwdata[7:0];
            end
            if (hit(i_paddr, cia_pkg::IDX_VECT)) begin
                vect_r <= i_pwdata[7:0];
            end
        end
    end

    // Lock bit: set only, cleared by reset alone
    always_ff @(posedge i_core_clk) begin
        if (!i_reset_n) begin
            lock_r <= 1'b0;
        end else if (wr && hit(i_paddr, cia_pkg::IDX_LOCK) &&
                     i_pwdata[cia_pkg::B_LOCK]) begin
            lock_r <= 1'b1;
        end
    end

    // Read data captured in the setup cycle
    always_ff @(posedge i_core_clk) begin
        if (!i_reset_n) begin
            prdata_r <= 32'h0000_0000;
        end else if (rd && !i_penable) begin
            prdata_r <= 32'h0000_0000;
            if (hit(i_paddr, cia_pkg::IDX_CTRL)) begin
                prdata_r[7:0] <= ctrl_r;
            end
            if (hit(i_paddr, cia_pkg::IDX_EDGE)) begin
                prdata_r[7:0] <= edge_r;
            end
            if (hit(i_paddr, cia_pkg::IDX_PEND)) begin
                prdata_r[7:0] <= pend_r;
            end
            if (hit(i_paddr, cia_pkg::IDX_MASK)) begin
                prdata_r[7:0] <= mask_r;
            end
            if (hit(i_paddr, cia_pkg::IDX_PRIO)) begin
                prdata_r[7:0] <= prio_r;
            end
            if (hit(i_paddr, cia_pkg::IDX_VECT)) begin
                prdata_r[7:0] <= vect_r;
            end
            if (hit(i_paddr, cia_pkg::IDX_LOCK)) begin
                prdata_r[cia_pkg::B_LOCK] <= lock_r;
            end
            if (hit(i_paddr, cia_pkg::IDX_STAT)) begin
                prdata_r[7:0] <= {o_int_req, o_imc_busy, win_top_r,
                                  win_prio_r, win_chan_r[1:0]};
            end
        end
    end

    always_comb begin
        o_pslverr = 1'b0;
        if (i_psel && i_penable) begin
            o_pslverr = !(hit(i_paddr, cia_pkg::IDX_CTRL) ||
                hit(i_paddr, cia_pkg::IDX_EDGE) ||
                hit(i_paddr, cia_pkg::IDX_PEND) ||
                hit(i_paddr, cia_pkg::IDX_MASK) ||
                hit(i_paddr, cia_pkg::IDX_PRIO) ||
                hit(i_paddr, cia_pkg::IDX_VECT) ||
                hit(i_paddr, cia_pkg::IDX_LOCK) ||
                (hit(i_paddr, cia_pkg::IDX_STAT) && !i_pwrite));
        end
    end

    assign o_pready = 1'b1;
    assign o_prdata = prdata_r;
    assign o_int_req = (state_r == cia_pkg::CIA_REQ);
    assign o_int_abort = o_int_req && !i_write_done;
    assign o_int_ack = ack;
    assign o_imc_busy = imc.busy;
    assign o_vector = vector_r;
    assign o_top_level = win_top_r;
    assign o_mft_enable = ctrl_r[cia_pkg::B_MFT];
endmodule // cia_arbiter
`default_nettype wire

// [verification/cia_arbiter_chk.sv]
// Port assertions for the interrupt arbiter
`default_nettype none
module cia_arbiter_chk (
    input wire logic i_core_clk,
    input wire logic i_reset_n,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [cia_pkg::PADDR_W-1:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic i_write_done,
    input wire logic i_instr_end,
    input wire logic i_wfi,
    input wire logic i_stack_in_rf,
    input wire logic i_segment_push_enable,
    input wire logic o_int_req,
    input wire logic o_int_abort,
    input wire logic o_int_ack,
    input wire logic o_imc_busy,
    input wire logic [6:0] o_vector,
    input wire logic o_mft_enable
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] ph_r;
    logic [4:0] len_r;
    logic [4:0] cnt_r;
    wire logic wd7 = i_pwdata[7];
    wire logic ctrl_wr = i_psel && i_penable && i_pwrite
        && i_paddr == {cia_pkg::IDX_CTRL, 2'b00};
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (!i_reset_n);
    // Mirror of the five-cycle sample phase
    always_ff @(posedge i_core_clk) begin
        if (!i_reset_n || ph_r == 3'h4) begin
            ph_r <= 3'h0;
        end else begin
            ph_r <= ph_r + 3'h1;
        end
    end
    // Expected machine cycle length, taken in the ack cycle
    always_ff @(posedge i_core_clk) begin
        if (!i_reset_n) begin
            len_r <= 5'h00;
        end else if (o_int_ack) begin
            len_r <= cia_pkg::IMC_BASE
                + (i_stack_in_rf ? cia_pkg::IMC_STACK_RF : 5'h00)
                + (i_segment_push_enable ? cia_pkg::IMC_SEG_PUSH : 5'h00)
                + (i_wfi ? cia_pkg::IMC_WAKE : 5'h00);
        end
    end
    always_ff @(posedge i_core_clk) begin
        if (!i_reset_n || o_int_ack) begin
            cnt_r <= 5'h00;
        end else if (o_imc_busy) begin
            cnt_r <= cnt_r + 5'h01;
        end
    end
    chk_abort_level:
    assert property (o_int_abort == (o_int_req && !i_write_done))
        else $error("abort does not follow request and write state");
    chk_abort_ack:
    assert property (o_int_req && !i_write_done |=> o_int_ack)
        else $error("abortable request not acknowledged next cycle");
    chk_req_held:
    assert property (o_int_req && i_write_done && !i_instr_end |=> o_int_req)
        else $error("request dropped before instruction end");
    chk_req_grid:
    assert property ($rose(o_int_req) |-> ph_r == 3'h0)
        else $error("request raised off the sample grid");
    chk_ack_once:
    assert property (o_int_ack |=> !o_int_ack && o_imc_busy)
        else $error("ack not a single cycle followed by busy");
    chk_imc_length:
    assert property ($fell(o_imc_busy) |-> cnt_r == len_r)
        else $error("machine cycle length wrong");
    chk_mft_bit:
    assert property (ctrl_wr |=> o_mft_enable == $past(wd7))
        else $error("timer enable does not follow control bit 7");
    chk_vector_hold:
    assert property (o_imc_busy && $past(o_imc_busy) |-> $stable(o_vector))
        else $error("vector changed during machine cycle");
endmodule // cia_arbiter_chk
bind cia_arbiter cia_arbiter_chk cia_arbiter_chk_inst (.i_core_clk,
    .i_reset_n, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata,
    .i_write_done, .i_instr_end, .i_wfi, .i_stack_in_rf,
    .i_segment_push_enable, .o_int_req, .o_int_abort, .o_int_ack,
    .o_imc_busy, .o_vector, .o_mft_enable);
`default_nettype wire

// [verification/cia_core_model.sv]
// Core sequencer model answering interrupt requests
`default_nettype none
module cia_core_model (
    input wire logic i_core_clk,
    input wire logic i_reset_n,
    input wire logic i_int_req,
    input wire logic i_slow,
    output logic o_write_done,
    output logic o_instr_end
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] cnt_r;
    // Slow mode: a write already done, instruction must finish
    assign o_write_done = i_slow;
    assign o_instr_end = i_int_req && cnt_r == 2'h3;
    always_ff @(posedge i_core_clk) begin
        if (!i_reset_n || !i_int_req) begin
            cnt_r <= 2'h0;
        end else if (i_slow && cnt_r != 2'h3) begin
            cnt_r <= cnt_r + 2'h1;
        end
    end
endmodule // cia_core_model
`default_nettype wire

// [verification/tb.sv]
// Self-checking bench for the interrupt arbiter
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_core_clk = 0, i_reset_n = 0, i_psel = 0, i_penable = 0;
    logic i_pwrite = 0, i_top_pin = 0, i_wfi = 0, i_stack_in_rf = 0;
    logic i_segment_push_enable = 0, i_ei = 0, i_di = 0, i_iret = 0;
    logic i_iret_top = 0, slow = 0, i_write_done, i_instr_end, se;
    logic [9:0] i_paddr = '0;
    logic [31:0] i_pwdata = '0, o_prdata;
    logic [7:0] i_ext_pin = '0, i_periph_event = '0, rd;
    logic o_pready, o_pslverr, o_int_req, o_int_abort, o_int_ack;
    logic o_imc_busy, o_top_level, o_mft_enable, top_seen;
    logic [6:0] o_vector, vec_seen;
    int err_total = 0, comparisons = 0, len;
    always #10 i_core_clk = ~i_core_clk;
    cia_arbiter cia_arbiter_inst (.i_core_clk, .i_reset_n, .i_psel,
        .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .o_prdata, .o_pready,
        .o_pslverr, .i_ext_pin, .i_periph_event, .i_top_pin, .i_write_done,
        .i_instr_end, .i_wfi, .i_stack_in_rf, .i_segment_push_enable, .i_ei,
        .i_di, .i_iret, .i_iret_top, .o_int_req, .o_int_abort, .o_int_ack,
        .o_imc_busy, .o_vector, .o_top_level, .o_mft_enable);
    cia_core_model cia_core_model_inst (.i_core_clk, .i_reset_n,
        .i_int_req(o_int_req), .i_slow(slow), .o_write_done(i_write_done),
        .o_instr_end(i_instr_end));
    task automatic chk(input logic [31:0] got, exp, input string m);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch at %0t: %s", $time, m);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, d);
        i_psel <= 1'b1;
        i_pwrite <= w;
        i_paddr <= {a, 2'b00};
        i_pwdata <= {24'h0000_00, d};
        @(posedge i_core_clk);
        i_penable <= 1'b1;
        @(posedge i_core_clk);
        while (o_pready !== 1'b1) @(posedge i_core_clk);
        rd = o_prdata[7:0];
        se = o_pslverr;
        i_psel <= 1'b0;
        i_penable <= 1'b0;
        @(posedge i_core_clk);
    endtask
    task automatic rdchk(input logic [7:0] a, exp);
        apb(1'b0, a, 8'h00);
        chk({24'h0000_00, rd}, {24'h0000_00, exp}, "register read");
    endtask
    task automatic pulse(input int w);
        i_iret <= (w == 0);
        i_di <= (w == 1);
        i_ei <= (w == 2);
        @(posedge i_core_clk);
        i_iret <= 1'b0;
        i_di <= 1'b0;
        i_ei <= 1'b0;
        @(posedge i_core_clk);
    endtask
    task automatic idle_chk();
        logic seen;
        seen = 1'b0;
        // No request in any of the cycles
        repeat (15) begin
            @(posedge i_core_clk);
            seen = seen | o_int_req | o_imc_busy;
        end
        chk(32'(seen), 32'h0000_0000, "unexpected request");
    endtask
    task automatic run_ack();
        int i;
        i = 0;
        len = 0;
        while (o_int_ack !== 1'b1 && i < 200) begin
            @(posedge i_core_clk);
            i++;
        end
        chk(32'(o_int_ack), 32'h0000_0001, "no acknowledge");
        vec_seen = o_vector;
        top_seen = o_top_level;
        @(posedge i_core_clk);
        while (o_imc_busy === 1'b1 && len < 40) begin
            len++;
            @(posedge i_core_clk);
        end
    endtask
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        #400000;
        err_total++;
        $display("watchdog expired");
        test_done();
    end
    initial begin
        repeat (20) @(posedge i_core_clk);
        i_reset_n <= 1'b1;
        @(posedge i_core_clk);
        rdchk(cia_pkg::IDX_CTRL, 8'h87);
        chk(32'(o_mft_enable), 32'h0000_0001, "timer enable");
        rdchk(cia_pkg::IDX_EDGE, 8'h00);
        apb(1'b1, cia_pkg::IDX_CTRL, 8'h17);
        chk(32'(o_mft_enable), 32'h0000_0000, "timer disable");
        apb(1'b0, 8'h10, 8'h00);
        chk(32'(se), 32'h0000_0001, "unmapped access");
        $display("test registers done");
        apb(1'b1, cia_pkg::IDX_PEND, 8'h01);
        idle_chk();
        i_periph_event <= 8'h20;
        @(posedge i_core_clk);
        i_periph_event <= 8'h00;
        @(posedge i_core_clk);
        rdchk(cia_pkg::IDX_PEND, 8'h21);
        apb(1'b1, cia_pkg::IDX_MASK, 8'h02);
        apb(1'b1, cia_pkg::IDX_PEND, 8'h02);
        idle_chk();
        apb(1'b1, cia_pkg::IDX_PEND, 8'h00);
        rdchk(cia_pkg::IDX_PEND, 8'h00);
        $display("test pending and mask done");
        apb(1'b1, cia_pkg::IDX_PRIO, 8'hfc);
        apb(1'b1, cia_pkg::IDX_VECT, 8'ha0);
        apb(1'b1, cia_pkg::IDX_MASK, 8'h03);
        for (int k = 0; k < 4; k++) begin
            i_stack_in_rf <= k[0];
            i_segment_push_enable <= k[1];
            i_wfi <= (k == 3);
            slow <= k[0];
            apb(1'b1, cia_pkg::IDX_PEND, (k == 2) ? 8'h03 : 8'h02);
            run_ack();
            chk(32'(len), 32'(18 + 2 * k[0] + 2 * k[1] + (k == 3)),
                "machine cycle length");
            chk(32'(vec_seen), (k == 2) ? 32'h50 : 32'h51, "vector");
            rdchk(cia_pkg::IDX_PEND, (k == 2) ? 8'h02 : 8'h00);
            apb(1'b1, cia_pkg::IDX_PEND, 8'h00);
            rdchk(cia_pkg::IDX_CTRL, 8'h07);
            pulse(0);
            rdchk(cia_pkg::IDX_CTRL, 8'h17);
        end
        pulse(1);
        rdchk(cia_pkg::IDX_CTRL, 8'h07);
        pulse(2);
        rdchk(cia_pkg::IDX_CTRL, 8'h17);
        $display("test acknowledge done");
        apb(1'b1, cia_pkg::IDX_MASK, 8'h00);
        apb(1'b1, cia_pkg::IDX_EDGE, 8'h04);
        rdchk(cia_pkg::IDX_EDGE, 8'h04);
        i_ext_pin <= 8'h08;
        repeat (6) @(posedge i_core_clk);
        rdchk(cia_pkg::IDX_PEND, 8'h00);
        i_ext_pin <= 8'h04;
        repeat (6) @(posedge i_core_clk);
        rdchk(cia_pkg::IDX_PEND, 8'h0c);
        apb(1'b1, cia_pkg::IDX_PEND, 8'h00);
        $display("test pin edges done");
        apb(1'b1, cia_pkg::IDX_VECT, 8'h08);
        apb(1'b1, cia_pkg::IDX_CTRL, 8'h37);
        i_top_pin <= 1'b1;
        run_ack();
        chk(32'(vec_seen), 32'h0000_0006, "top vector");
        chk(32'(top_seen), 32'h0000_0001, "top winner");
        rdchk(cia_pkg::IDX_CTRL, 8'h37);
        apb(1'b1, cia_pkg::IDX_CTRL, 8'h57);
        idle_chk();
        rdchk(cia_pkg::IDX_CTRL, 8'h57);
        apb(1'b1, cia_pkg::IDX_LOCK, 8'h80);
        run_ack();
        chk(32'(top_seen), 32'h0000_0001, "locked top request");
        rdchk(cia_pkg::IDX_CTRL, 8'h17);
        $display("test top level done");
        test_done();
    end
endmodule // tb
`default_nettype wire
